// ===== hdl/drive_status_word_packer.v
// Packs drive state flags into cyclic drive and encoder status words.
`timescale 1ns/1ps
`default_nettype none
`include "status_word_defs.vh"
module drive_status_word_packer #(
    parameter XIST_W = `SW_XIST_W
) (
    // Clock and reset.
    input  wire              I_MCLK,
    input  wire              I_SRST,
    // Telegram selection.
    input  wire [7:0]        I_TELEGRAM,
    // Common drive state flags.
    input  wire              I_READY_ON,
    input  wire              I_READY_OP,
    input  wire              I_OP_ENABLED,
    input  wire              I_FAULT,
    input  wire              I_NO_COAST_STOP,
    input  wire              I_NO_QUICK_STOP,
    input  wire              I_ON_INHIBIT,
    input  wire              I_ALARM,
    input  wire              I_CTRL_REQ,
    input  wire [1:0]        I_ALARM_CLASS,
    input  wire              I_FIXED_STOP_MOVE,
    input  wire              I_PULSES_ON,
    input  wire [3:0]        I_SIGN_OF_LIFE,
    // Speed and torque flags.
    input  wire              I_SPEED_DEV_OK,
    input  wire              I_SPEED_CMP,
    input  wire              I_TORQUE_CTRL,
    input  wire              I_RAMP_OFF,
    input  wire              I_BRAKE_OPEN,
    input  wire              I_INT_INHIBIT,
    // Positioning flags.
    input  wire              I_DC_LINK_BLOCKED,
    input  wire              I_FOLLOW_SETPOINT,
    input  wire              I_FOLLOW_ERR_OK,
    input  wire              I_TARGET_REACHED,
    input  wire              I_REF_SET,
    input  wire              I_BLOCK_ACK,
    input  wire              I_SETPOINT_FIXED,
    input  wire              I_ACCEL,
    input  wire              I_DECEL,
    // Encoder 1 flags.
    input  wire [3:0]        I_ENC_FUNC_ACTIVE,
    input  wire [3:0]        I_ENC_CAPT_READY,
    input  wire              I_ENC_ACK_FAULT,
    input  wire              I_ENC_ABS_CYCLIC,
    input  wire              I_ENC_PARKED,
    input  wire              I_ENC_FAULT,
    input  wire [XIST_W-1:0] I_ENC_CAPT_VALUE,
    input  wire [XIST_W-1:0] I_ENC_FAULT_CODE,
    // Status words.
    output reg  [15:0]       O_DRIVE_STATUS_WORD_1,
    output reg  [15:0]       O_DRIVE_STATUS_WORD_2,
    output reg  [15:0]       O_ENCODER1_STATUS_WORD,
    output reg  [XIST_W-1:0] O_ENCODER_POSITION_VALUE_2,
    output reg               O_LAYOUT_VALID
);
    // Telegram class codes, one-hot.
    localparam [2:0] LAY_NONE  = 3'h1;
    localparam [2:0] LAY_SPEED = 3'h2;
    localparam [2:0] LAY_POS   = 3'h4;

    // Classify a telegram number into a word layout.
    function [2:0] layout_of;
        input [7:0] tgm;
        begin
            case (tgm)
                `SW_TGM_102, `SW_TGM_105: layout_of = LAY_SPEED;
                `SW_TGM_7, `SW_TGM_9,
                `SW_TGM_110, `SW_TGM_111: layout_of = LAY_POS;
                default: layout_of = LAY_NONE;
            endcase
        end
    endfunction

    wire [2:0]        layout;
    wire              has_word2;
    wire [15:0]       enc_word;
    wire [XIST_W-1:0] enc_xist2;
    reg  [15:0]       next_word1;
    reg  [15:0]       next_word2;

    assign layout = layout_of(I_TELEGRAM);
    // Telegram 7 carries no second word, so it must read as zero there.
    assign has_word2 = (layout == LAY_SPEED) ||
                       ((layout == LAY_POS) && (I_TELEGRAM != `SW_TGM_7));

    // Encoder word packing.
    encoder_status_pack #(
        .XIST_W (XIST_W)
    ) u_enc (
        .i_func_active (I_ENC_FUNC_ACTIVE),
        .i_capt_ready  (I_ENC_CAPT_READY),
        .i_ack_fault   (I_ENC_ACK_FAULT),
        .i_abs_cyclic  (I_ENC_ABS_CYCLIC),
        .i_parked      (I_ENC_PARKED),
        .i_fault       (I_ENC_FAULT),
        .i_capt_value  (I_ENC_CAPT_VALUE),
        .i_fault_code  (I_ENC_FAULT_CODE),
        .o_word        (enc_word),
        .o_xist2       (enc_xist2)
    );

    // Assemble drive words for the selected layout; all else stays zero.
    always @* begin
        next_word1 = `SW_RESET_WORD;
        next_word2 = `SW_RESET_WORD;
        case (layout)
            LAY_SPEED: begin
                next_word1[`DW1_BASE_LSB +: 8] = {I_ALARM, I_ON_INHIBIT,
                    I_NO_QUICK_STOP, I_NO_COAST_STOP, I_FAULT,
                    I_OP_ENABLED, I_READY_OP, I_READY_ON};
                next_word1[`DW1_DEV_OK] = I_SPEED_DEV_OK;
                next_word1[`DW1_CTRL_REQ] = I_CTRL_REQ;
                next_word1[`DW1_CMP_REACHED] = I_SPEED_CMP;
                next_word1[`DW1_ACLASS_LSB +: 2] = I_ALARM_CLASS;
                next_word1[`DW1_TORQUE] = I_TORQUE_CTRL;
                next_word2[`DW2_RAMP_OFF] = I_RAMP_OFF;
                next_word2[`DW2_INT_INHIBIT] = I_INT_INHIBIT;
                next_word2[`DW2_BRAKE_OPEN] = I_BRAKE_OPEN;
            end
            LAY_POS: begin
                next_word1[`DW1_BASE_LSB +: 8] = {I_ALARM, I_ON_INHIBIT,
                    I_NO_QUICK_STOP, I_NO_COAST_STOP, I_FAULT,
                    I_FOLLOW_SETPOINT, I_DC_LINK_BLOCKED,
                    I_READY_ON};
                next_word1[`DW1_FOLLOW_OK] = I_FOLLOW_ERR_OK;
                next_word1[`DW1_CTRL_REQ] = I_CTRL_REQ;
                next_word1[`DW1_TARGET] = I_TARGET_REACHED;
                next_word1[`DW1_REF_SET] = I_REF_SET;
                next_word1[`DW1_BLOCK_ACK] = I_BLOCK_ACK;
                next_word1[`DW1_SP_FIXED] = I_SETPOINT_FIXED;
                next_word1[`DW1_ACCEL] = I_ACCEL;
                next_word1[`DW1_DECEL] = I_DECEL;
                if (has_word2) begin
                    next_word2[`DW2_ACLASS_LSB +: 2] = I_ALARM_CLASS;
                    next_word2[`DW2_PULSES_ON] = I_PULSES_ON;
                end
            end
            default: begin
                next_word1 = `SW_RESET_WORD;
            end
        endcase
        // Shared word 2 fields for both layouts.
        if (has_word2) begin
            next_word2[`DW2_FIXED_STOP] = I_FIXED_STOP_MOVE;
            next_word2[`DW2_LIFE_LSB +: 4] = I_SIGN_OF_LIFE;
        end
    end

    // Register every word so the controller samples glitch-free values.
    always @(posedge I_MCLK) begin
        if (I_SRST) begin
            O_DRIVE_STATUS_WORD_1      <= `SW_RESET_WORD;
            O_DRIVE_STATUS_WORD_2      <= `SW_RESET_WORD;
            O_ENCODER1_STATUS_WORD     <= `SW_RESET_WORD;
            O_ENCODER_POSITION_VALUE_2 <= {XIST_W{1'b0}};
            O_LAYOUT_VALID             <= 1'b0;
        end else begin
            O_DRIVE_STATUS_WORD_1      <= next_word1;
            O_DRIVE_STATUS_WORD_2      <= next_word2;
            O_ENCODER1_STATUS_WORD     <= enc_word;
            O_ENCODER_POSITION_VALUE_2 <= enc_xist2;
            O_LAYOUT_VALID             <= (layout != LAY_NONE);
        end
    end
endmodule
`default_nettype wire

// ===== hdl/status_word_defs.vh
// Bit positions, telegram codes and widths for the drive status word packer.
`ifndef STATUS_WORD_DEFS_VH
`define STATUS_WORD_DEFS_VH

`define SW_WORD_W        16
`define SW_TGM_W         8
`define SW_XIST_W        32

// Telegram numbers.
`define SW_TGM_102       8'h66
`define SW_TGM_105       8'h69
`define SW_TGM_7         8'h07
`define SW_TGM_9         8'h09
`define SW_TGM_110       8'h6E
`define SW_TGM_111       8'h6F

// Drive status word 1, common and speed layout.
`define DW1_BASE_LSB     0
`define DW1_DEV_OK       8
`define DW1_CTRL_REQ     9
`define DW1_CMP_REACHED  10
`define DW1_ACLASS_LSB   11
`define DW1_TORQUE       14
// Drive status word 1, positioning layout.
`define DW1_FOLLOW_OK    8
`define DW1_TARGET       10
`define DW1_REF_SET      11
`define DW1_BLOCK_ACK    12
`define DW1_SP_FIXED     13
`define DW1_ACCEL        14
`define DW1_DECEL        15

// Drive status word 2.
`define DW2_RAMP_OFF     4
`define DW2_BRAKE_OPEN   5
`define DW2_INT_INHIBIT  6
`define DW2_ACLASS_LSB   5
`define DW2_FIXED_STOP   8
`define DW2_PULSES_ON    10
`define DW2_LIFE_LSB     12

// Encoder 1 status word.
`define EW_FUNC_LSB      0
`define EW_CAPT_LSB      4
`define EW_ACK_FAULT     11
`define EW_ABS_CYCLIC    13
`define EW_PARKED        14
`define EW_FAULT         15

`define SW_RESET_WORD    16'h0000

`endif

// ===== hdl/encoder_status_pack.v
// Encoder 1 status word and position value 2 selection.
`timescale 1ns/1ps
`default_nettype none
`include "status_word_defs.vh"
module encoder_status_pack #(
    parameter XIST_W = `SW_XIST_W
) (
    // Encoder state flags.
    input  wire [3:0]        i_func_active,
    input  wire [3:0]        i_capt_ready,
    input  wire              i_ack_fault,
    input  wire              i_abs_cyclic,
    input  wire              i_parked,
    input  wire              i_fault,
    // Position sources.
    input  wire [XIST_W-1:0] i_capt_value,
    input  wire [XIST_W-1:0] i_fault_code,
    // Packed results.
    output reg  [15:0]       o_word,
    output reg  [XIST_W-1:0] o_xist2
);
    // Unused positions stay at zero so the controller never sees stale bits.
    always @* begin
        o_word = `SW_RESET_WORD;
        o_word[`EW_FUNC_LSB +: 4] = i_func_active;
        o_word[`EW_CAPT_LSB +: 4] = i_capt_ready;
        o_word[`EW_ACK_FAULT] = i_ack_fault;
        o_word[`EW_ABS_CYCLIC] = i_abs_cyclic;
        o_word[`EW_PARKED] = i_parked;
        o_word[`EW_FAULT] = i_fault;
        // A fault code takes priority over any captured position.
        o_xist2 = i_fault ? i_fault_code : i_capt_value;
    end
endmodule
`default_nettype wire

// ===== tb/status_word_monitor.sv
// Checker for the packed status words seen at the packer's ports.
`timescale 1ns/1ps
`default_nettype none
module status_word_monitor #(
    parameter XIST_W = 32
) (
    input wire logic              I_MCLK,
    input wire logic              I_SRST,
    input wire logic [7:0]        I_TELEGRAM,
    input wire logic [1:0]        I_ALARM_CLASS,
    input wire logic [3:0]        I_SIGN_OF_LIFE,
    input wire logic              I_ENC_FAULT,
    input wire logic [XIST_W-1:0] I_ENC_CAPT_VALUE,
    input wire logic [XIST_W-1:0] I_ENC_FAULT_CODE,
    input wire logic [15:0]       O_DRIVE_STATUS_WORD_1,
    input wire logic [15:0]       O_DRIVE_STATUS_WORD_2,
    input wire logic [15:0]       O_ENCODER1_STATUS_WORD,
    input wire logic [XIST_W-1:0] O_ENCODER_POSITION_VALUE_2,
    input wire logic              O_LAYOUT_VALID
);
    default clocking dc @(posedge I_MCLK); endclocking
    default disable iff (I_SRST);
    // Last cycle's telegram and reset, since every word lags its cause by one.
    logic [7:0] tg;
    logic       rs;
    logic       spd;
    logic       pos2;
    always @(posedge I_MCLK) begin
        tg <= I_TELEGRAM;
        rs <= I_SRST;
    end
    assign spd = !rs && (tg == 8'h66 || tg == 8'h69);
    assign pos2 = !rs && (tg == 8'h09 || tg == 8'h6E || tg == 8'h6F);
    a_layout_valid: assert property (!rs |->
        O_LAYOUT_VALID == (spd || pos2 || tg == 8'h07)) else $error("Bad valid.");
    a_speed_class: assert property (spd |->
        O_DRIVE_STATUS_WORD_1[12:11] == $past(I_ALARM_CLASS)) else $error("Bad.");
    a_speed_reserved: assert property (spd |->
        !O_DRIVE_STATUS_WORD_1[13] && !O_DRIVE_STATUS_WORD_1[15]) else $error("R.");
    a_life_count: assert property ((spd || pos2) |->
        O_DRIVE_STATUS_WORD_2[15:12] == $past(I_SIGN_OF_LIFE)) else $error("L.");
    a_pos_class: assert property (pos2 |->
        O_DRIVE_STATUS_WORD_2[6:5] == $past(I_ALARM_CLASS)) else $error("C.");
    a_enc_fault: assert property ($rose(I_ENC_FAULT) |=>
        O_ENCODER1_STATUS_WORD[15]) else $error("Encoder fault bit missing.");
    a_fault_code: assert property (!rs |-> O_ENCODER_POSITION_VALUE_2 ==
        ($past(I_ENC_FAULT) ? $past(I_ENC_FAULT_CODE) : $past(I_ENC_CAPT_VALUE)))
        else $error("Position value 2 source wrong.");
    a_enc_reserved: assert property (!rs |->
        (O_ENCODER1_STATUS_WORD & 16'h1700) == 16'h0000) else $error("Enc res.");
    a_reset_clear: assert property (rs |-> O_DRIVE_STATUS_WORD_1 == 16'h0000 &&
        O_DRIVE_STATUS_WORD_2 == 16'h0000 && !O_LAYOUT_VALID) else $error("Rst.");
    c_torque: cover property (spd && O_DRIVE_STATUS_WORD_1[14]);
    c_pulses: cover property (pos2 && O_DRIVE_STATUS_WORD_2[10]);
    c_refused: cover property (!rs && !O_LAYOUT_VALID);
endmodule
bind drive_status_word_packer status_word_monitor #(.XIST_W(XIST_W)) u_mon (
    .I_MCLK(I_MCLK), .I_SRST(I_SRST), .I_TELEGRAM(I_TELEGRAM),
    .I_ALARM_CLASS(I_ALARM_CLASS), .I_SIGN_OF_LIFE(I_SIGN_OF_LIFE),
    .I_ENC_FAULT(I_ENC_FAULT), .I_ENC_CAPT_VALUE(I_ENC_CAPT_VALUE),
    .I_ENC_FAULT_CODE(I_ENC_FAULT_CODE),
    .O_DRIVE_STATUS_WORD_1(O_DRIVE_STATUS_WORD_1),
    .O_DRIVE_STATUS_WORD_2(O_DRIVE_STATUS_WORD_2),
    .O_ENCODER1_STATUS_WORD(O_ENCODER1_STATUS_WORD),
    .O_ENCODER_POSITION_VALUE_2(O_ENCODER_POSITION_VALUE_2),
    .O_LAYOUT_VALID(O_LAYOUT_VALID));
`default_nettype wire

// ===== tb/status_word_reader.sv
// Controller side model that reads the encoder 1 status word and drops reserved bits.
`timescale 1ns/1ps
`default_nettype none
module status_word_reader (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_enc_word,
    output logic      [15:0] o_enc_used
);
    // Reserved bits are masked so a stray value can never steer the controller.
    always @(posedge i_clk) begin
        o_enc_used <= i_enc_word & 16'hE8FF;
    end
endmodule
`default_nettype wire

// ===== tb/tb_drive_status_word_packer.sv
// Self-checking bench for the drive status word packer.
`timescale 1ns/1ps
`default_nettype none
module tb_drive_status_word_packer;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  tgm = 8'h00;
    logic [43:0] f = 44'h0;
    logic [31:0] cv = 32'h0;
    logic [31:0] fc = 32'h0;
    wire logic [15:0] w1, w2, ew;
    wire logic [31:0] xv;
    wire logic        vld;
    wire logic [15:0] used;
    logic [15:0] prev_enc = 16'h0000;
    logic [15:0] exp_enc;
    int          fails = 0;
    int          compares = 0;
    logic [7:0]  codes [8] = '{8'h66, 8'h69, 8'h07, 8'h09, 8'h6E, 8'h6F,
                               8'h01, 8'hFF};
    // 40 MHz clock.
    always #12.5 mclk = ~mclk;
    drive_status_word_packer dut (.I_MCLK(mclk), .I_SRST(srst),
        .I_TELEGRAM(tgm), .I_READY_ON(f[0]), .I_READY_OP(f[1]),
        .I_OP_ENABLED(f[2]), .I_FAULT(f[3]), .I_NO_COAST_STOP(f[4]),
        .I_NO_QUICK_STOP(f[5]), .I_ON_INHIBIT(f[6]), .I_ALARM(f[7]),
        .I_CTRL_REQ(f[8]), .I_ALARM_CLASS(f[10:9]), .I_FIXED_STOP_MOVE(f[11]),
        .I_PULSES_ON(f[12]), .I_SIGN_OF_LIFE(f[16:13]), .I_SPEED_DEV_OK(f[17]),
        .I_SPEED_CMP(f[18]), .I_TORQUE_CTRL(f[19]), .I_RAMP_OFF(f[20]),
        .I_BRAKE_OPEN(f[21]), .I_INT_INHIBIT(f[22]),
        .I_DC_LINK_BLOCKED(f[23]), .I_FOLLOW_SETPOINT(f[24]),
        .I_FOLLOW_ERR_OK(f[25]), .I_TARGET_REACHED(f[26]), .I_REF_SET(f[27]),
        .I_BLOCK_ACK(f[28]), .I_SETPOINT_FIXED(f[29]), .I_ACCEL(f[30]),
        .I_DECEL(f[31]), .I_ENC_FUNC_ACTIVE(f[35:32]),
        .I_ENC_CAPT_READY(f[39:36]), .I_ENC_ACK_FAULT(f[40]),
        .I_ENC_ABS_CYCLIC(f[41]), .I_ENC_PARKED(f[42]), .I_ENC_FAULT(f[43]),
        .I_ENC_CAPT_VALUE(cv), .I_ENC_FAULT_CODE(fc),
        .O_DRIVE_STATUS_WORD_1(w1), .O_DRIVE_STATUS_WORD_2(w2),
        .O_ENCODER1_STATUS_WORD(ew), .O_ENCODER_POSITION_VALUE_2(xv),
        .O_LAYOUT_VALID(vld));
    status_word_reader reader (.i_clk(mclk), .i_enc_word(ew), .o_enc_used(used));
    // Telegram classes and the expected words built bit by bit.
    function automatic logic sp(input logic [7:0] t);
        return t == 8'h66 || t == 8'h69;
    endfunction
    function automatic logic ps(input logic [7:0] t);
        return t == 8'h07 || t == 8'h09 || t == 8'h6E || t == 8'h6F;
    endfunction
    function automatic logic [15:0] ex1(input logic [7:0] t, input logic [43:0] v);
        if (sp(t))
            return {1'h0, v[19], 1'h0, v[10:9], v[18], v[8], v[17], v[7:0]};
        if (ps(t))
            return {v[31:26], v[8], v[25], v[7:3], v[24], v[23], v[0]};
        return 16'h0000;
    endfunction
    function automatic logic [15:0] ex2(input logic [7:0] t, input logic [43:0] v);
        if (sp(t))
            return {v[16:13], 3'h0, v[11], 1'h0, v[22:20], 4'h0};
        if (ps(t) && t != 8'h07)
            return {v[16:13], 1'h0, v[12], 1'h0, v[11], 1'h0, v[10:9], 5'h00};
        return 16'h0000;
    endfunction
    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Let one edge take the inputs, then compare just after it settles.
    task automatic step;
        @(posedge mclk);
        #1;
        chk16("word1", srst ? 16'h0000 : ex1(tgm, f), w1);
        chk16("word2", srst ? 16'h0000 : ex2(tgm, f), w2);
        exp_enc = srst ? 16'h0000 : {f[43:41], 1'h0, f[40], 3'h0, f[39:32]};
        chk16("enc", exp_enc, ew);
        // The controller model lags one edge and keeps only defined bits.
        chk16("used", prev_enc, used);
        prev_enc = exp_enc;
        chk32("xist2", srst ? 32'h0 : (f[43] ? fc : cv), xv);
        chk16("valid", {15'h0000, !srst && (sp(tgm) || ps(tgm))},
              {15'h0000, vld});
    endtask
    task automatic test_done;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Every telegram with all flags high then low; reserved bits must stay 0.
    initial begin
        void'($urandom(32'hACB5533C));
        repeat (10) @(posedge mclk);
        #1;
        srst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            tgm = codes[i % 8];
            f = (i < 8) ? {44{1'b1}} : 44'h0;
            cv = 32'hFFFFFFFF;
            step();
        end
        $display("test corner done");
        for (int i = 0; i < 300; i++) begin
            tgm = codes[$urandom_range(7)];
            f = 44'({$urandom(), $urandom()});
            cv = $urandom();
            fc = $urandom();
            srst = (i == 150);
            step();
        end
        $display("test random done");
        test_done();
    end
    // A hang is cut off well past the expected few hundred cycles.
    initial begin
        #50000;
        fails++;
        test_done();
    end
endmodule
`default_nettype wire
